// file: dv/scf_mgr_model.sv
// Purpose: system manager model facing the supervisor's far side
// Assumes: backplane pull-ups on the hold and fault lines
// Notes: one decoded transaction per call, answer sampled a cycle later
`timescale 1ns/1ps

module scf_mgr_model
  import scf_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // management ports
  output scf_req_t [1:0] mgmt_req,
  input wire scf_rsp_t [1:0] mgmt_rsp,
  // open-drain lines
  input wire logic sys_hold_o,
  input wire logic sys_hold_oe_n,
  input wire logic fault_o,
  input wire logic fault_oe_n,
  output logic hold_line,
  output logic fault_line
);
  // pull-up wins while nobody pulls low
  assign hold_line = sys_hold_oe_n ? 1'b1 : sys_hold_o;
  assign fault_line = fault_oe_n ? 1'b1 : fault_o;

  initial mgmt_req = '0;

  task automatic xfer(input int p, input logic [6:0] a, input logic [7:0] c,
                      input logic w, input logic [7:0] d, output scf_rsp_t r);
    @(posedge clk_sys);
    mgmt_req[p] <= '{valid: 1'b1, addr: a, cmd: c, wr: w, wdata: d};
    @(posedge clk_sys);
    mgmt_req[p] <= '0;
    #1;
    r = mgmt_rsp[p];
  endtask : xfer
endmodule : scf_mgr_model

// file: dv/scf_supervisor_tb_top.sv
// Purpose: self-checking bench of the supply supervisor
// Assumes: shortened counts, 10 MHz clock
// Notes: manager model drives the management ports
`timescale 1ns/1ps

module scf_supervisor_tb_top
  import scf_pkg::*;
;
  localparam int ON = 0;
  localparam int HOLD = 1;
  logic clk_sys, reset, enable_n, inhibit_n, slot_addr_parity_n;
  logic [4:0] slot_addr_n;
  logic sys_hold_o, sys_hold_oe_n, fault_o, fault_oe_n, outputs_on, hold_line, fault_line;
  logic [2:0] obs;
  scf_meas_t meas;
  scf_req_t [1:0] mgmt_req;
  scf_rsp_t [1:0] mgmt_rsp;
  scf_rsp_t r;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  assign obs = {fault_oe_n, sys_hold_oe_n, outputs_on};

  scf_supervisor #(.DEB_CYC(4), .SAMPLE_CYC(20), .PWRUP_SMP(2), .HOLDOFF_SMP(3),
    .RETRY_SMP(4), .CRANK_SMP(6)) i_scf_supervisor (
    .clk_sys(clk_sys), .reset(reset), .enable_n(enable_n), .inhibit_n(inhibit_n),
    .slot_addr_n(slot_addr_n), .slot_addr_parity_n(slot_addr_parity_n),
    .sys_hold_i(hold_line), .sys_hold_o(sys_hold_o), .sys_hold_oe_n(sys_hold_oe_n),
    .fault_i(fault_line), .fault_o(fault_o), .fault_oe_n(fault_oe_n), .meas(meas),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp), .outputs_on(outputs_on));

  scf_mgr_model i_scf_mgr_model (
    .clk_sys(clk_sys), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
    .sys_hold_o(sys_hold_o), .sys_hold_oe_n(sys_hold_oe_n), .fault_o(fault_o),
    .fault_oe_n(fault_oe_n), .hold_line(hold_line), .fault_line(fault_line));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int k, input logic v);
    int i;
    i = 0;
    while (obs[k] !== v && i < 400) begin
      @(posedge clk_sys);
      i++;
    end
    #1;
    chk(16'(obs[k]), 16'(v));
  endtask : wt

  task automatic ex(input int p, input logic [6:0] a, input logic [7:0] c,
                    input logic [1:0] va, input logic [15:0] d);
    i_scf_mgr_model.xfer(p, a, c, 1'b0, 8'h00, r);
    chk({14'h0, r.valid, r.ack}, {14'h0, va});
    chk(r.data, d);
  endtask : ex

  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    enable_n = 1'b1;
    inhibit_n = 1'b1;
    slot_addr_n = 5'h1E;
    slot_addr_parity_n = 1'b1;
    meas = '0;
    meas.temp_a = 8'h28;
    meas.temp_b = 8'h32;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk(16'(obs), 16'h0);
    wt(HOLD, 1'b1);
    chk(16'(fault_oe_n), 16'h1);
    ex(0, 7'h21, 8'h21, 2'b11, 16'h0032);
    ex(1, 7'h21, 8'h92, 2'b11, 16'h3228);
    ex(1, 7'h20, 8'h21, 2'b10, 16'h0000);
    ex(0, 7'h21, 8'h77, 2'b10, 16'h0000);
    meas.temp_a <= 8'h3C;
    ex(1, 7'h21, 8'h21, 2'b11, 16'h003C);
    enable_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    enable_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h0);
    enable_n <= 1'b0;
    inhibit_n <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h0);
    inhibit_n <= 1'b1;
    wt(ON, 1'b1);
    ex(0, 7'h21, 8'h55, 2'b11, 16'h00C1);
    enable_n <= 1'b1;
    wt(ON, 1'b0);
    enable_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h0);
    wt(ON, 1'b1);
    i_scf_mgr_model.xfer(0, 7'h21, 8'h55, 1'b1, 8'h20, r);
    ex(1, 7'h21, 8'h55, 2'b11, 16'h00E1);
    meas.temp_b <= 8'h55;
    repeat (2) @(posedge clk_sys);
    ex(1, 7'h21, 8'h55, 2'b11, 16'h00C1);
    meas.temp_b <= 8'h32;
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        meas.out_ov <= 1'b1;
      else
        meas.out_oc <= 1'b1;
      wt(ON, 1'b0);
      chk(16'(fault_oe_n), 16'h0);
      i_scf_mgr_model.xfer(k, 7'h21, 8'h55, 1'b0, 8'h00, r);
      chk({15'h0, r.data[k + 1]}, 16'h1);
      chk({15'h0, r.data[6]}, 16'h0);
      repeat (150) @(posedge clk_sys);
      chk(16'(obs), 16'h2);
      meas.out_ov <= 1'b0;
      meas.out_oc <= 1'b0;
      wt(ON, 1'b1);
      chk(16'(fault_oe_n), 16'h1);
    end
    meas.temp_a <= 8'h5F;
    wt(ON, 1'b0);
    meas.temp_a <= 8'h4C;
    repeat (80) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h0);
    meas.temp_a <= 8'h4B;
    wt(ON, 1'b1);
    meas.crank <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h1);
    wt(ON, 1'b0);
    meas.crank <= 1'b0;
    wt(ON, 1'b1);
    slot_addr_n <= 5'h1C;
    slot_addr_parity_n <= 1'b0;
    ex(0, 7'h21, 8'h21, 2'b11, 16'h004B);
    meas.in_ov <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(16'(outputs_on), 16'h1);
    meas.in_ov <= 1'b0;
    meas.in_uv <= 1'b1;
    wt(HOLD, 1'b0);
    chk(16'(obs), 16'h0);
    ex(1, 7'h21, 8'h21, 2'b00, 16'h0000);
    meas.in_uv <= 1'b0;
    wt(HOLD, 1'b1);
    ex(0, 7'h23, 8'h21, 2'b11, 16'h004B);
    slot_addr_parity_n <= 1'b1;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    wt(HOLD, 1'b1);
    ex(1, 7'h20, 8'h21, 2'b11, 16'h004B);
    print_verdict();
  end
endmodule : scf_supervisor_tb_top

// file: hdl/scf_defines.svh
// Purpose: constants of the supply control and fault supervisor
// Assumes: 10 MHz system clock
// Notes: times kept in their own unit, counts derived from them
`ifndef SCF_DEFINES_SVH
`define SCF_DEFINES_SVH

`define SCF_CLK_MHZ 10
`define SCF_SAMPLE_US 200
`define SCF_SAMPLE_CYC (`SCF_SAMPLE_US * `SCF_CLK_MHZ)
`define SCF_INQUAL_US 1000
`define SCF_INQUAL_SMP ((`SCF_INQUAL_US + `SCF_SAMPLE_US - 1) / `SCF_SAMPLE_US)
`define SCF_RETRY_MS 1000
`define SCF_CRANK_S 30
`define SCF_DEB_US 50
`define SCF_HOLDOFF_MS 100
`define SCF_PWRUP_MS 10

`define SCF_OT_ENTER_C 95
`define SCF_OT_HYST_C 20
`define SCF_OT_WARN_C 85

`define SCF_ADDR_BASE 7'h20
`define SCF_CMD_TEMP_MAX 8'h21
`define SCF_CMD_TEMP_BOTH 8'h92
`define SCF_CMD_STATUS 8'h55

`define SCF_ST_ON 0
`define SCF_ST_OV 1
`define SCF_ST_OC 2
`define SCF_ST_OT 3
`define SCF_ST_CRANK 4
`define SCF_ST_WARN 5
`define SCF_ST_FAULT_LINE 6
`define SCF_ST_HOLD_LINE 7
`define SCF_STATUS_RESET 8'h00

`endif

// file: hdl/scf_pkg.sv
// Purpose: types of the supply control and fault supervisor
// Assumes: constants live in scf_defines.svh
// Notes: one state struct carries all registers of the top module
package scf_pkg;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_RUN = 2'b01,
    ST_RETRY = 2'b10,
    ST_INFAULT = 2'b11
  } scf_state_t;

  typedef struct packed {
    logic in_uv;
    logic in_ov;
    logic out_ov;
    logic out_oc;
    logic crank;
    logic signed [7:0] temp_a;
    logic signed [7:0] temp_b;
  } scf_meas_t;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] cmd;
    logic wr;
    logic [7:0] wdata;
  } scf_req_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] data;
  } scf_rsp_t;

  typedef struct packed {
    scf_state_t st;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [1:0] deb;
    logic [1:0][15:0] deb_cnt;
    logic [15:0] smp_cnt;
    logic [6:0] addr;
    logic [19:0] pwr_cnt;
    logic [19:0] holdoff;
    logic [19:0] retry;
    logic [19:0] crank_cnt;
    logic [7:0] inbad;
    logic out_on;
    logic hold_rel;
    logic fault_rel;
    logic od_low;
    logic ov;
    logic oc;
    logic ot;
    logic crank_trip;
    logic warn;
    scf_rsp_t [1:0] rsp;
  } scf_regs_t;

endpackage : scf_pkg

// file: hdl/scf_supervisor.sv
// Purpose: control and fault supervision of a backplane power module
// Assumes: measurement flags and temperatures come from same-clock logic
// Notes: management ports are decoded transactions, one per port
// Notes on behaviour
// - request and block pins active low, float high
// - both control pins pass a debounce filter
// - minimum hold-off between request-driven turn-ons
// - slot address pins active low, float high
// - slot address latched once at power-up
// - both management ports answer identically, same address
// - fault follows hold at power-up, low when out-of-spec
// - hold low during power-up, released when ready
// - command 0x21 returns hotter temperature reading
// - command 0x92 returns both temperature readings
// - input out of range 1ms shuts everything
// - input fault recovers through power-up, keeping over-temperature and crank state
// - measurements sampled every 200us drive protection
// - output overvoltage asserts fault, shuts outputs down
// - overvoltage shutdown retries every second
// - overcurrent shuts outputs, retries each second when cleared
// - either sensor at 95C shuts outputs down
// - leave over-temperature 20C below threshold
// - manager sets warn bit, cleared at 85C
// - cranking full power limited to 30 seconds
// - address is base plus five slot bits
// - bad slot parity falls back to base
`include "scf_defines.svh"
`timescale 1ns/1ps

module scf_supervisor
  import scf_pkg::*;
#(
  parameter int unsigned DEB_CYC = `SCF_DEB_US * `SCF_CLK_MHZ,
  parameter int unsigned SAMPLE_CYC = `SCF_SAMPLE_CYC,
  parameter int unsigned PWRUP_SMP = (`SCF_PWRUP_MS * 1000) / `SCF_SAMPLE_US,
  parameter int unsigned HOLDOFF_SMP = (`SCF_HOLDOFF_MS * 1000) / `SCF_SAMPLE_US,
  parameter int unsigned RETRY_SMP = (`SCF_RETRY_MS * 1000) / `SCF_SAMPLE_US,
  parameter int unsigned CRANK_SMP = (`SCF_CRANK_S * 1000000) / `SCF_SAMPLE_US
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control pins
  input wire logic enable_n,
  input wire logic inhibit_n,
  input wire logic [4:0] slot_addr_n,
  input wire logic slot_addr_parity_n,
  // open-drain lines
  input wire logic sys_hold_i,
  output logic sys_hold_o,
  output logic sys_hold_oe_n,
  input wire logic fault_i,
  output logic fault_o,
  output logic fault_oe_n,
  // measurements
  input wire scf_meas_t meas,
  // management ports
  input wire scf_req_t [1:0] mgmt_req,
  output scf_rsp_t [1:0] mgmt_rsp,
  // power stage
  output logic outputs_on
);

  localparam logic signed [7:0] OT_ENTER = 8'(`SCF_OT_ENTER_C);
  localparam logic signed [7:0] OT_LEAVE = 8'(`SCF_OT_ENTER_C - `SCF_OT_HYST_C);
  localparam logic signed [7:0] OT_WARN = 8'(`SCF_OT_WARN_C);
  localparam logic [7:0] INQUAL = 8'(`SCF_INQUAL_SMP);

  scf_regs_t r;
  scf_regs_t n;

  logic tick;
  logic in_bad;
  logic out_bad;
  logic signed [7:0] tmax;
  logic request;
  logic answering;
  logic [1:0] hit;
  logic [7:0] status;
  logic [6:0] slot_addr;

  // ------------------------------------------------------------
  // measurement view
  // ------------------------------------------------------------
  assign tick = (r.smp_cnt == 16'(SAMPLE_CYC - 1));
  assign in_bad = meas.in_uv | meas.in_ov;
  assign out_bad = meas.out_ov | meas.out_oc;
  assign tmax = (meas.temp_a > meas.temp_b) ? meas.temp_a : meas.temp_b;
  // active low: enable low asks, inhibit low blocks; pins float high
  assign request = !r.deb[0] && r.deb[1];
  assign answering = (r.st == ST_RUN) || (r.st == ST_RETRY);
  assign status = {r.sync2[8], r.sync2[9], r.warn, r.crank_trip, r.ot, r.oc, r.ov, r.out_on};

  // inverted pins give the five low address bits, odd parity with parity pin
  always_comb begin
    slot_addr = `SCF_ADDR_BASE | {2'b00, ~r.sync2[6:2]};
    if (!(^{~r.sync2[6:2], ~r.sync2[7]})) begin
      slot_addr = `SCF_ADDR_BASE;
    end
  end

  // ------------------------------------------------------------
  // per port address match
  // ------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      assign hit[gp] = mgmt_req[gp].valid && (mgmt_req[gp].addr == r.addr);
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic want;
    want = 1'b0;
    n = r;
    n.sync1 = {fault_i, sys_hold_i, slot_addr_parity_n, slot_addr_n, inhibit_n, enable_n};
    n.sync2 = r.sync1;
    n.smp_cnt = tick ? 16'h0000 : r.smp_cnt + 16'h0001;

    for (int i = 0; i < 2; i++) begin
      if (r.sync2[i] == r.deb[i]) begin
        n.deb_cnt[i] = 16'h0000;
      end else if (r.deb_cnt[i] >= 16'(DEB_CYC - 1)) begin
        n.deb[i] = r.sync2[i];
        n.deb_cnt[i] = 16'h0000;
      end else begin
        n.deb_cnt[i] = r.deb_cnt[i] + 16'h0001;
      end
    end

    if (tick) begin
      n.inbad = in_bad ? ((r.inbad == 8'hFF) ? r.inbad : r.inbad + 8'h01) : 8'h00;
      if (tmax >= OT_ENTER) begin
        n.ot = 1'b1;
      end else if (tmax <= OT_LEAVE) begin
        n.ot = 1'b0;
      end
      if (r.holdoff != 20'h00000) begin
        n.holdoff = r.holdoff - 20'h00001;
      end
      if (meas.crank && r.out_on) begin
        if (r.crank_cnt >= 20'(CRANK_SMP - 1)) begin
          n.crank_trip = 1'b1;
        end else begin
          n.crank_cnt = r.crank_cnt + 20'h00001;
        end
      end else if (!meas.crank) begin
        n.crank_cnt = 20'h00000;
        n.crank_trip = 1'b0;
      end
    end
    want = request && !n.ot && !n.crank_trip;

    for (int p = 0; p < 2; p++) begin
      n.rsp[p] = '0;
      if (mgmt_req[p].valid && answering) begin
        n.rsp[p].valid = 1'b1;
        if (hit[p]) begin
          n.rsp[p].ack = 1'b1;
          case (mgmt_req[p].cmd)
            `SCF_CMD_TEMP_MAX: begin
              n.rsp[p].data = {8'h00, tmax};
            end
            `SCF_CMD_TEMP_BOTH: begin
              n.rsp[p].data = {meas.temp_b, meas.temp_a};
            end
            `SCF_CMD_STATUS: begin
              n.rsp[p].data = {8'h00, status};
              if (mgmt_req[p].wr) begin
                n.warn = mgmt_req[p].wdata[`SCF_ST_WARN];
              end
            end
            default: begin
              n.rsp[p].ack = 1'b0;
            end
          endcase
        end
      end
    end
    if (tmax >= OT_WARN) begin
      n.warn = 1'b0;
    end

    case (r.st)
      ST_POWERUP: begin
        n.out_on = 1'b0;
        n.hold_rel = 1'b0;
        n.fault_rel = 1'b0;
        if (tick) begin
          if (r.pwr_cnt >= 20'(PWRUP_SMP - 1)) begin
            n.addr = slot_addr;
            n.st = ST_RUN;
            n.hold_rel = 1'b1;
            n.fault_rel = 1'b1;
            n.pwr_cnt = 20'h00000;
          end else begin
            n.pwr_cnt = r.pwr_cnt + 20'h00001;
          end
        end
      end
      ST_RUN: begin
        if (tick && out_bad && r.out_on) begin
          n.out_on = 1'b0;
          n.fault_rel = 1'b0;
          n.ov = meas.out_ov;
          n.oc = meas.out_oc;
          n.retry = 20'(RETRY_SMP);
          n.st = ST_RETRY;
        end else if (!want) begin
          n.out_on = 1'b0;
        end else if (!r.out_on && r.holdoff == 20'h00000) begin
          n.out_on = 1'b1;
          n.holdoff = 20'(HOLDOFF_SMP);
        end
      end
      ST_RETRY: begin
        n.out_on = 1'b0;
        n.fault_rel = 1'b0;
        if (tick) begin
          if (r.retry > 20'h00001) begin
            n.retry = r.retry - 20'h00001;
          end else if (out_bad) begin
            n.ov = meas.out_ov;
            n.oc = meas.out_oc;
            n.retry = 20'(RETRY_SMP);
          end else begin
            n.st = ST_RUN;
            n.out_on = want;
            n.fault_rel = 1'b1;
            n.ov = 1'b0;
            n.oc = 1'b0;
          end
        end
      end
      ST_INFAULT: begin
        n.out_on = 1'b0;
        n.hold_rel = 1'b0;
        n.fault_rel = 1'b0;
        n.rsp = '0;
        if (tick && !in_bad) begin
          n.st = ST_POWERUP;
          n.pwr_cnt = 20'h00000;
          n.holdoff = 20'h00000;
          n.ov = 1'b0;
          n.oc = 1'b0;
          n.warn = 1'b0;
        end
      end
      default: begin
        n.st = ST_POWERUP;
      end
    endcase

    if (tick && in_bad && r.inbad >= INQUAL - 8'h01) begin
      n.st = ST_INFAULT;
      n.out_on = 1'b0;
      n.hold_rel = 1'b0;
      n.fault_rel = 1'b0;
      n.rsp = '0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r <= '0;
      r.st <= ST_POWERUP;
      r.sync1 <= 10'h3FF;
      r.sync2 <= 10'h3FF;
      r.deb <= 2'h3;
      r.addr <= `SCF_ADDR_BASE;
    end else begin
      r <= n;
    end
  end

  assign outputs_on = r.out_on;
  assign sys_hold_o = r.od_low;
  assign sys_hold_oe_n = r.hold_rel;
  assign fault_o = r.od_low;
  assign fault_oe_n = r.fault_rel;
  assign mgmt_rsp = r.rsp;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  hold_release_a: assert property ($rose(sys_hold_oe_n) |-> $past(r.st) == ST_POWERUP)
    else $error("hold released outside power-up");
  fault_track_a: assert property (r.st == ST_POWERUP |-> !fault_oe_n && !sys_hold_oe_n)
    else $error("fault not tracking hold at power-up");
  addr_fixed_a: assert property (r.st != ST_POWERUP && $past(r.st) != ST_POWERUP |-> $stable(r.addr))
    else $error("slot address changed after power-up");
  input_fault_a: assert property (tick && in_bad && r.inbad == INQUAL - 8'h01 |=> r.st == ST_INFAULT && !outputs_on && !sys_hold_oe_n)
    else $error("input fault not taken after qualification");
  ot_shut_a: assert property (tick && tmax >= OT_ENTER |=> ##1 !outputs_on)
    else $error("outputs on at over-temperature");
  ov_shut_a: assert property (r.st == ST_RUN && r.out_on && tick && meas.out_ov && !(in_bad && r.inbad >= INQUAL - 8'h01) |=> !outputs_on && !fault_oe_n && r.retry == 20'(RETRY_SMP))
    else $error("overvoltage did not shut down");
  retry_wait_a: assert property (r.st == ST_RETRY |-> !outputs_on && !fault_oe_n)
    else $error("output or fault released while waiting to retry");
  holdoff_gap_a: assert property ($rose(outputs_on) && $past(r.st) == ST_RUN |-> $past(r.holdoff) == 20'h00000)
    else $error("turn-on inside hold-off");
  port_answer_a: assert property (mgmt_req[1].valid && answering && !(tick && in_bad) |=> mgmt_rsp[1].valid)
    else $error("redundant port did not answer");
  warn_clear_a: assert property (tmax >= OT_WARN |=> !r.warn)
    else $error("warning bit not cleared at warning temperature");

endmodule : scf_supervisor
